// *** verilog/cbcg_top.sv ***
// Purpose: Boot configuration, fetch start, debug targets, sleep and clock gating
// Assumes: Configuration inputs synchronous to core_clk; APB on core_clk
// Notes: srst wins over clockEn; clockEn low freezes every register except the gated counters under scan force
`timescale 1ns/1ps
`default_nettype none
`include "cbcg_cfg.svh"

module cbcg_top
    import cbcg_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter bit CLUSTER_SUPPORT = 1'b0
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic clockEn,
    input wire logic scanGateForce,
    input wire logic fetchPermit,
    input wire logic fetchGrant,
    input wire logic clusterClockEn,
    input wire logic wakeEvent,
    input wire logic debugReq,
    input wire logic debugFault,
    input wire logic debugReturn,
    input wire logic [31:0] bootAddr,
    input wire logic [31:0] trapVecAddr,
    input wire logic [31:0] debugEntryTarget,
    input wire logic [31:0] debugFaultTarget,
    input wire logic [31:0] threadIdentityIn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fetchReq,
    output logic [31:0] fetchAddr,
    output logic sleepIndication
);

    cbcg_state_t state_reg, state_next;
    logic started_reg, started_next;
    logic fetchReq_reg, fetchReq_next;
    logic [31:0] pc_reg, pc_next;
    logic [31:0] savedPc_reg, savedPc_next;
    logic sleepInd_reg, sleepInd_next;
    logic [31:0] trapVec_reg, trapVec_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] activeCnt_reg, activeCnt_next;
    logic [31:0] runCnt_reg, runCnt_next;
    logic sleepClk, topClk;
    logic sleepGateEn, topGateEn;
    logic apbSetup, apbDone, wrDone, sleepCmd;

    // Address decode shared by read mux and error flag
    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        logic [7:0] a8;
        a8 = a[7:0];
        isMapped = (a[1:0] == 2'h0) && (a8 <= `CBCG_OFF_RUN_CNT)
            && (a == ADDR_W'(a8));
    endfunction : isMapped

    // Word-wide increment, used by the fetch address and both counters
    function automatic logic [31:0] bump(input logic [31:0] v, input logic [31:0] step);
        bump = v + step;
    endfunction : bump

    // APB phases: one wait state so read data comes from a flop
    assign apbSetup = clockEn && psel && penable && !pready_reg;
    assign apbDone = clockEn && psel && penable && pready_reg;
    assign wrDone = apbDone && pwrite && isMapped(paddr);
    assign sleepCmd = wrDone && (paddr[7:0] == `CBCG_OFF_CTRL)
        && pwdata[`CBCG_CTRL_SLEEP_BIT];

    // Core front-end control: start, run, sleep, debug
    always_comb
    begin
        state_next = state_reg;
        started_next = started_reg;
        pc_next = pc_reg;
        savedPc_next = savedPc_reg;
        unique case (state_reg)
            CBCG_WAIT:
            begin
                pc_next = bootAddr;
                if (fetchPermit)
                begin
                    state_next = CBCG_RUN;
                    started_next = 1'b1;
                end
            end
            CBCG_RUN:
            begin
                if (debugReq)
                begin
                    savedPc_next = fetchGrant ? bump(pc_reg, `CBCG_PC_STEP) : pc_reg;
                    pc_next = debugEntryTarget;
                    state_next = CBCG_DEBUG;
                end
                else if (sleepCmd)
                begin
                    state_next = CBCG_SLEEP;
                end
                else if (fetchGrant)
                begin
                    pc_next = bump(pc_reg, `CBCG_PC_STEP);
                end
            end
            CBCG_SLEEP:
            begin
                // Debug also wakes the core, straight into debug mode
                if (debugReq)
                begin
                    savedPc_next = pc_reg;
                    pc_next = debugEntryTarget;
                    state_next = CBCG_DEBUG;
                end
                else if (wakeEvent)
                begin
                    state_next = CBCG_RUN;
                end
            end
            CBCG_DEBUG:
            begin
                if (debugFault)
                begin
                    pc_next = debugFaultTarget;
                end
                else if (debugReturn)
                begin
                    pc_next = savedPc_reg;
                    state_next = CBCG_RUN;
                end
                else if (fetchGrant)
                begin
                    pc_next = bump(pc_reg, `CBCG_PC_STEP);
                end
            end
        endcase
        // Permission level no longer matters once started
        fetchReq_next = (state_next == CBCG_RUN) || (state_next == CBCG_DEBUG);
        sleepInd_next = (state_next == CBCG_SLEEP);
    end

    // Front-end registers; reset wins over the clock enable
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg <= CBCG_WAIT;
            started_reg <= 1'b0;
            fetchReq_reg <= 1'b0;
            pc_reg <= `CBCG_WORD_RST;
            savedPc_reg <= `CBCG_WORD_RST;
            sleepInd_reg <= 1'b0;
        end
        else if (clockEn)
        begin
            state_reg <= state_next;
            started_reg <= started_next;
            fetchReq_reg <= fetchReq_next;
            pc_reg <= pc_next;
            savedPc_reg <= savedPc_next;
            sleepInd_reg <= sleepInd_next;
        end
    end

    // APB slave: writes land at the edge that samples pready high
    always_comb
    begin
        trapVec_next = trapVec_reg;
        prdata_next = prdata_reg;
        pready_next = apbSetup;
        pslverr_next = apbSetup && !isMapped(paddr);
        if (wrDone && (paddr[7:0] == `CBCG_OFF_TRAP_VEC))
        begin
            // Mode field is fixed; only the base is writable
            trapVec_next = {pwdata[31:`CBCG_TVEC_BASE_LSB], `CBCG_TVEC_MODE_RST};
        end
        if (apbSetup)
        begin
            prdata_next = `CBCG_WORD_RST;
            if (!pwrite && isMapped(paddr))
            begin
                unique case (paddr[7:0])
                    `CBCG_OFF_STATUS:
                    begin
                        prdata_next[1:0] = state_reg;
                        prdata_next[`CBCG_STAT_STARTED_BIT] = started_reg;
                        prdata_next[`CBCG_STAT_SLEEP_BIT] = sleepInd_reg;
                        prdata_next[`CBCG_STAT_DEBUG_BIT] = (state_reg == CBCG_DEBUG);
                    end
                    `CBCG_OFF_FETCH_PC: prdata_next = pc_reg;
                    `CBCG_OFF_TRAP_VEC: prdata_next = trapVec_reg;
                    `CBCG_OFF_M_THREAD_ID: prdata_next = threadIdentityIn;
                    `CBCG_OFF_U_THREAD_ID: prdata_next = threadIdentityIn;
                    `CBCG_OFF_ACTIVE_CNT: prdata_next = activeCnt_reg;
                    `CBCG_OFF_RUN_CNT: prdata_next = runCnt_reg;
                    default: prdata_next = `CBCG_WORD_RST; // Control reads as zero
                endcase
            end
        end
    end

    // APB and trap vector registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            // Synchronous reset, so the strap value may be loaded directly
            trapVec_reg <= {trapVecAddr[31:`CBCG_TVEC_BASE_LSB], `CBCG_TVEC_MODE_RST};
            prdata_reg <= `CBCG_WORD_RST;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else if (clockEn)
        begin
            trapVec_reg <= trapVec_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Gate in the sleep control; cluster enable counts only when supported
    assign sleepGateEn = srst || (clockEn && (!sleepInd_reg
        || (CLUSTER_SUPPORT && clusterClockEn)));
    // Top-level gate: idle until the first fetch is permitted
    assign topGateEn = srst || (clockEn && started_reg);

    cbcg_clock_gate u_sleepGate
    (
        .clkIn(core_clk),
        .gateEnable(sleepGateEn),
        .scanGateForce(scanGateForce),
        .gatedClk(sleepClk)
    );

    cbcg_clock_gate u_topGate
    (
        .clkIn(core_clk),
        .gateEnable(topGateEn),
        .scanGateForce(scanGateForce),
        .gatedClk(topClk)
    );

    // Counters on gated clocks show how long each gate stayed open
    always_comb
    begin
        activeCnt_next = bump(activeCnt_reg, 32'h0000_0001);
        runCnt_next = bump(runCnt_reg, 32'h0000_0001);
    end

    // Under scan force these count even with clockEn low; test mode only
    always_ff @(posedge sleepClk)
    begin
        if (srst)
        begin
            activeCnt_reg <= `CBCG_WORD_RST;
        end
        else
        begin
            activeCnt_reg <= activeCnt_next;
        end
    end

    always_ff @(posedge topClk)
    begin
        if (srst)
        begin
            runCnt_reg <= `CBCG_WORD_RST;
        end
        else
        begin
            runCnt_reg <= runCnt_next;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign fetchReq = fetchReq_reg;
    assign fetchAddr = pc_reg;
    assign sleepIndication = sleepInd_reg;

    // Checks on core_clk
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_no_early_fetch: assert property (!started_reg |-> !fetchReq_reg)
        else $error("fetch requested before permission");
    a_fetch_start: assert property (clockEn && state_reg == CBCG_WAIT && fetchPermit
        |=> fetchReq_reg && started_reg)
        else $error("fetch did not start after permission");
    a_start_sticky: assert property (started_reg |=> started_reg && $stable(started_reg))
        else $error("started flag dropped");
    a_sleep_flag: assert property (sleepInd_reg == (state_reg == CBCG_SLEEP))
        else $error("sleep indication disagrees with state");
    a_boot_pc: assert property (clockEn && state_reg == CBCG_WAIT && fetchPermit
        |=> fetchAddr == $past(bootAddr))
        else $error("first fetch address not boot address");
    a_trap_reset: assert property ($past(srst) |-> trapVec_reg[31:2] == $past(trapVecAddr[31:2]))
        else $error("trap vector base not loaded at reset");
    a_debug_entry: assert property (clockEn && state_reg == CBCG_RUN && debugReq
        |=> state_reg == CBCG_DEBUG && fetchAddr == $past(debugEntryTarget))
        else $error("debug entry target not taken");
    a_debug_fault: assert property (clockEn && state_reg == CBCG_DEBUG && debugFault
        |=> fetchAddr == $past(debugFaultTarget) ##0 state_reg == CBCG_DEBUG)
        else $error("debug fault target not taken");
    a_thread_read: assert property (apbSetup && !pwrite
        && (paddr[7:0] == `CBCG_OFF_M_THREAD_ID || paddr[7:0] == `CBCG_OFF_U_THREAD_ID)
        |=> pready && prdata == $past(threadIdentityIn))
        else $error("thread identity read wrong");

    c_start: cover property (state_reg == CBCG_WAIT ##1 state_reg == CBCG_RUN);
    c_sleep_wake: cover property (state_reg == CBCG_SLEEP ##[1:20] state_reg == CBCG_RUN);
    c_debug_fault: cover property (state_reg == CBCG_DEBUG && debugFault && clockEn);
    c_apb_error: cover property (pready && pslverr);

endmodule : cbcg_top

`default_nettype wire

// *** verilog/cbcg_cfg.svh ***
// Purpose: Offsets, field positions, reset values and steps for the boot/config block
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes: Definitions only
`ifndef CBCG_CFG_SVH
`define CBCG_CFG_SVH

// Register byte offsets
`define CBCG_OFF_CTRL 8'h00
`define CBCG_OFF_STATUS 8'h04
`define CBCG_OFF_FETCH_PC 8'h08
`define CBCG_OFF_TRAP_VEC 8'h0c
`define CBCG_OFF_M_THREAD_ID 8'h10
`define CBCG_OFF_U_THREAD_ID 8'h14
`define CBCG_OFF_ACTIVE_CNT 8'h18
`define CBCG_OFF_RUN_CNT 8'h1c

// Control fields
`define CBCG_CTRL_SLEEP_BIT 0

// Status fields
`define CBCG_STAT_STARTED_BIT 2
`define CBCG_STAT_SLEEP_BIT 3
`define CBCG_STAT_DEBUG_BIT 4

// Trap vector layout: base above the mode field
`define CBCG_TVEC_BASE_LSB 2
`define CBCG_TVEC_MODE_RST 2'h0

// Fetch address step per granted fetch
`define CBCG_PC_STEP 32'h0000_0004

// Reset values
`define CBCG_WORD_RST 32'h0000_0000

`endif

// *** verilog/cbcg_pkg.sv ***
// Purpose: Types shared by the boot/config block
// Assumes: Used together with cbcg_cfg.svh
// Notes: Types only; numbers live in the header
package cbcg_pkg;

    // Control states of the core front end
    typedef enum logic [1:0]
    {
        CBCG_WAIT,
        CBCG_RUN,
        CBCG_SLEEP,
        CBCG_DEBUG
    } cbcg_state_t;

endpackage : cbcg_pkg

// *** verilog/cbcg_clock_gate.sv ***
// Purpose: Glitch-free clock gate with scan override
// Assumes: Enable inputs change only after the rising clock edge
// Notes: Behavioural latch; swap for a library cell in a real flow
`timescale 1ns/1ps
`default_nettype none

module cbcg_clock_gate
(
    input wire logic clkIn,
    input wire logic gateEnable,
    input wire logic scanGateForce,
    output logic gatedClk
);

    logic openLatch;
    logic heldAtRise;

    // Enable captured only in the low phase, so a late change cannot chop a pulse
    always_latch
    begin
        if (!clkIn)
        begin
            openLatch <= gateEnable | scanGateForce;
        end
    end

    // Clock passes only while the latch holds open
    assign gatedClk = clkIn & openLatch;

    a_gate_opens: assert property (@(posedge clkIn) (gateEnable || scanGateForce) |-> openLatch)
        else $error("clock gate closed while enabled");
    a_scan_forces: assert property (@(posedge clkIn) scanGateForce |-> openLatch)
        else $error("scan force did not open clock gate");

    // Latch value at each rise; it must not move while the clock is high
    always_ff @(posedge clkIn)
    begin
        heldAtRise <= openLatch;
    end

    a_gate_steady: assert property (@(negedge clkIn) openLatch == heldAtRise)
        else $error("clock gate changed while clock high");

endmodule : cbcg_clock_gate

`default_nettype wire

// *** testbench/cbcg_sys_model.sv ***
// Purpose: System-side model driving the configuration pins
// Assumes: New values drawn once at reset entry
// Notes: Addresses stay frozen while out of reset
`timescale 1ns/1ps
`default_nettype none

module cbcg_sys_model
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic startReq,
    output logic fetchPermit,
    output logic clusterClockEn,
    output logic [31:0] bootAddr,
    output logic [31:0] trapVecAddr,
    output logic [31:0] debugEntryTarget,
    output logic [31:0] debugFaultTarget,
    output logic [31:0] threadIdentityIn
);
    integer seed = 62827;
    logic srstSeen = 1'b0;

    // Cluster support is off, so its enable is tied low
    assign clusterClockEn = 1'b0;

    // Draw only on reset entry, so the last reset edge sees settled values
    always @(posedge core_clk)
    begin
        srstSeen <= srst;
        fetchPermit <= startReq && !srst;
        if (srst && !srstSeen)
        begin
            bootAddr <= $random(seed) & 32'hffff_fffe;
            trapVecAddr <= $random(seed);
            debugEntryTarget <= $random(seed) & 32'hffff_fffc;
            debugFaultTarget <= $random(seed) & 32'hffff_fffc;
            threadIdentityIn <= $random(seed);
        end
    end
endmodule : cbcg_sys_model

`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the boot/config block and its clock gate
// Assumes: One wait state on APB, fetch start one cycle after permission
// Notes: Expected fetch address kept by a small model in the bench
`timescale 1ns/1ps
`default_nettype none
`include "cbcg_cfg.svh"

module tb;
    logic core_clk = 1'b0, srst = 1'b1, clockEn = 1'b1, scanGateForce = 1'b0, startReq = 1'b0;
    logic fetchGrant = 1'b0, wakeEvent = 1'b0, debugReq = 1'b0, debugFault = 1'b0;
    logic debugReturn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic err, pready, pslverr, fetchReq;
    logic sleepIndication, fetchPermit, clusterClockEn;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd, a, r, expPc, prdata, fetchAddr;
    logic [31:0] bootAddr, trapVecAddr, debugEntryTarget, debugFaultTarget, threadIdentityIn;
    integer seed = 62827;
    int errorCnt = 0, cmpCount = 0;

    always #5 core_clk = ~core_clk;

    // Gates inside are behavioural; a library cell with the same ports replaces them
    cbcg_top #(.ADDR_W(8), .CLUSTER_SUPPORT(1'b0)) i_dut (.core_clk, .srst, .clockEn,
        .scanGateForce, .fetchPermit, .fetchGrant, .clusterClockEn, .wakeEvent, .debugReq,
        .debugFault, .debugReturn, .bootAddr, .trapVecAddr, .debugEntryTarget,
        .debugFaultTarget, .threadIdentityIn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fetchReq, .fetchAddr, .sleepIndication);

    cbcg_sys_model i_sys (.core_clk, .srst, .startReq, .fetchPermit, .clusterClockEn,
        .bootAddr, .trapVecAddr, .debugEntryTarget, .debugFaultTarget, .threadIdentityIn);

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic look(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : look

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        logic ok;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            #1;
            ok = pready;
            rd = prdata;
            err = pslverr;
            n++;
            @(posedge core_clk);
        end while (ok !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb answer", 32'h1, 32'(ok));
    endtask : apb

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        apb(1'b0, adr, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rdchk

    task automatic waitSleep(input logic v);
        int n;
        for (n = 0; n < 4 && sleepIndication !== v; n++)
            look(1);
        chk("sleep flag", 32'(v), 32'(sleepIndication));
    endtask : waitSleep

    // Reset held two cycles; outputs must come out quiet
    task automatic do_reset;
        @(posedge core_clk) srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        look(1);
        chk("fetch req", 32'h0, 32'(fetchReq));
        chk("sleep flag", 32'h0, 32'(sleepIndication));
        rdchk(`CBCG_OFF_TRAP_VEC, trapVecAddr & 32'hffff_fffc, "trap vector");
    endtask : do_reset

    // Hang guard, well beyond the length of the sequence
    initial
    begin
        #200000;
        errorCnt++;
        stop_test();
    end

    initial
    begin
        do_reset();
        // Top gate stays shut until fetching starts; scan force opens it anyway
        rdchk(`CBCG_OFF_RUN_CNT, 32'h0000_0000, "closed top gate");
        @(posedge core_clk) scanGateForce <= 1'b1;
        apb(1'b0, `CBCG_OFF_RUN_CNT, 32'h0000_0000);
        chk("forced top gate", 32'h1, 32'(rd != 32'h0000_0000));
        @(posedge core_clk) scanGateForce <= 1'b0;
        rdchk(`CBCG_OFF_M_THREAD_ID, threadIdentityIn, "machine id");
        rdchk(`CBCG_OFF_U_THREAD_ID, threadIdentityIn, "user id");
        apb(1'b1, `CBCG_OFF_TRAP_VEC, 32'h1234_5677);
        rdchk(`CBCG_OFF_TRAP_VEC, 32'h1234_5674, "trap vector write");
        apb(1'b1, 8'h40, 32'h0000_0001);
        chk("slave error", 32'h1, 32'(err));
        look(6);
        chk("fetch before start", 32'h0, 32'(fetchReq));
        $display("test config done");
        @(posedge core_clk) startReq <= 1'b1;
        @(posedge core_clk) startReq <= 1'b0;
        look(1);
        chk("fetch req", 32'h1, 32'(fetchReq));
        chk("first pc", bootAddr, fetchAddr);
        expPc = bootAddr;
        // Random grants, stalls and late permission pulses
        repeat (16)
        begin
            @(posedge core_clk);
            if (fetchGrant && clockEn)
                expPc += `CBCG_PC_STEP;
            r = $random(seed);
            fetchGrant <= r[0];
            clockEn <= r[1] | r[2];
            startReq <= r[3];
            #1 chk("fetch pc", expPc, fetchAddr);
        end
        @(posedge core_clk);
        if (fetchGrant && clockEn)
            expPc += `CBCG_PC_STEP;
        {fetchGrant, startReq, clockEn} <= 3'b001;
        look(1);
        chk("fetch pc", expPc, fetchAddr);
        rdchk(`CBCG_OFF_STATUS, 32'h0000_0005, "status run");
        $display("test fetch done");
        apb(1'b1, `CBCG_OFF_CTRL, 32'h0000_0001);
        waitSleep(1'b1);
        chk("fetch in sleep", 32'h0, 32'(fetchReq));
        rdchk(`CBCG_OFF_STATUS, 32'h0000_000e, "status sleep");
        apb(1'b0, `CBCG_OFF_ACTIVE_CNT, 32'h0);
        a = rd;
        rdchk(`CBCG_OFF_ACTIVE_CNT, a, "closed gate count");
        @(posedge core_clk) scanGateForce <= 1'b1;
        apb(1'b0, `CBCG_OFF_ACTIVE_CNT, 32'h0);
        chk("forced gate count", 32'h1, 32'(rd > a));
        @(posedge core_clk) scanGateForce <= 1'b0;
        @(posedge core_clk) wakeEvent <= 1'b1;
        @(posedge core_clk) wakeEvent <= 1'b0;
        waitSleep(1'b0);
        chk("pc after wake", expPc, fetchAddr);
        $display("test sleep done");
        @(posedge core_clk) debugReq <= 1'b1;
        @(posedge core_clk) debugReq <= 1'b0;
        look(0);
        chk("debug entry", debugEntryTarget, fetchAddr);
        rdchk(`CBCG_OFF_STATUS, 32'h0000_0017, "status debug");
        @(posedge core_clk) debugFault <= 1'b1;
        @(posedge core_clk) debugFault <= 1'b0;
        look(0);
        chk("debug fault", debugFaultTarget, fetchAddr);
        @(posedge core_clk) debugReturn <= 1'b1;
        @(posedge core_clk) debugReturn <= 1'b0;
        look(0);
        chk("debug return", expPc, fetchAddr);
        $display("test debug done");
        do_reset();
        look(4);
        chk("fetch after reset", 32'h0, 32'(fetchReq));
        $display("test reset done");
        stop_test();
    end
endmodule : tb

`default_nettype wire
